// ===== rtl/low_power_mode_controller.sv
// Power-mode controller: mode sequencing, clock and regulator control, wake handling
`include "lpm_regs.svh"
module low_power_mode_controller (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [15:0]             reg_rdata,
  input  wire logic               cpu_wait,
  input  wire logic               irq_or_event,
  input  wire lpm_pkg::stop_src_s stop_src,
  input  wire lpm_pkg::stby_src_s stby_src,
  output lpm_pkg::mode_e          mode_q,
  output lpm_pkg::osc_s           osc_q,
  output lpm_pkg::dom_s           dom_q,
  output logic                    core_rst_q,
  output logic                    rtc_wdg_keep_q
);
  logic [2:0]  req_mode_q;
  logic [1:0]  range_q;
  logic        keep_rtc_q;
  logic        vref_q;
  logic        go_q;
  logic [15:0] line_en_q;
  logic [2:0]  cause_q;
  logic [15:0] wake_cnt_q;
  logic        stop_wake;
  logic        stby_wake;
  logic [15:0] rdata_d;
  lpm_pkg::mode_e mode_d;
  lpm_pkg::osc_s  osc_d;
  lpm_pkg::dom_s  dom_d;

  stop_wake_gate u_stop (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .src      (stop_src),
    .line_en  (line_en_q),
    .keep_rtc (keep_rtc_q),
    .vref_on  (vref_q),
    .wake_q   (stop_wake)
  );

  stby_wake_gate u_stby (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .src      (stby_src),
    .keep_rtc (keep_rtc_q),
    .wake_q   (stby_wake)
  );

  // Control register; the go bit arms entry and self-clears once the core waits
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_mode_q <= 3'h0;
      range_q    <= `LPM_RANGE_RESET;
      keep_rtc_q <= 1'b1;
      vref_q     <= 1'b0;
      go_q       <= 1'b0;
    end else if (reg_wr && reg_addr == `LPM_ADDR_CTRL) begin
      req_mode_q <= reg_wdata[`LPM_CTRL_MODE_MSB:`LPM_CTRL_MODE_LSB];
      range_q    <= reg_wdata[`LPM_CTRL_RANGE_MSB:`LPM_CTRL_RANGE_LSB];
      keep_rtc_q <= reg_wdata[`LPM_CTRL_RTC_BIT];
      vref_q     <= reg_wdata[`LPM_CTRL_VREF_BIT];
      go_q       <= reg_wdata[`LPM_CTRL_GO_BIT];
    end else if (go_q && cpu_wait) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_en_q <= `LPM_WAKE_EN_RESET;
    end else if (reg_wr && reg_addr == `LPM_ADDR_WAKE_EN) begin
      line_en_q <= reg_wdata;
    end
  end

  // Mode sequencer; only one mode is ever held
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      lpm_pkg::MODE_RUN: begin
        if (go_q && cpu_wait) begin
          case (req_mode_q)
            3'b001:  mode_d = lpm_pkg::MODE_SLEEP;
            3'b011:  mode_d = lpm_pkg::MODE_LP_SLEEP;
            3'b100:  mode_d = lpm_pkg::MODE_STOP;
            3'b101:  mode_d = lpm_pkg::MODE_STANDBY;
            default: mode_d = lpm_pkg::MODE_RUN;
          endcase
        end else if (go_q && req_mode_q == 3'b010) begin
          mode_d = lpm_pkg::MODE_LP_RUN;
        end
      end
      lpm_pkg::MODE_LP_RUN: begin
        if (go_q && cpu_wait && req_mode_q == 3'b011) begin
          mode_d = lpm_pkg::MODE_LP_SLEEP;
        end else if (go_q && req_mode_q == 3'b000) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      lpm_pkg::MODE_SLEEP: begin
        if (irq_or_event) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      lpm_pkg::MODE_LP_SLEEP: begin
        if (irq_or_event) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      lpm_pkg::MODE_STOP: begin
        if (wake_cnt_q == 16'(`LPM_STOP_WAKE_NEED)) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      lpm_pkg::MODE_STANDBY: begin
        if (core_rst_q && wake_cnt_q == 16'(`LPM_STBY_RST_CYC)) begin
          mode_d = lpm_pkg::MODE_RUN;
        end
      end
      default: mode_d = lpm_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= lpm_pkg::MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Wake latency counter; a wake source seen in Stop/Standby starts the sequence
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt_q <= 16'h0000;
      core_rst_q <= 1'b0;
    end else if (mode_q == lpm_pkg::MODE_STOP) begin
      if (wake_cnt_q != 16'h0000 || stop_wake) begin
        wake_cnt_q <= wake_cnt_q + 16'h0001;
      end
    end else if (mode_q == lpm_pkg::MODE_STANDBY) begin
      if (core_rst_q) begin
        wake_cnt_q <= wake_cnt_q + 16'h0001;
      end else if (stby_wake) begin
        core_rst_q <= 1'b1;
        wake_cnt_q <= 16'h0001;
      end
    end else begin
      wake_cnt_q <= 16'h0000;
      core_rst_q <= 1'b0;
    end
  end

  // Last wake cause, kept across Standby like the clock/reset status register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_q <= 3'h0;
    end else if (mode_q == lpm_pkg::MODE_STANDBY && stby_wake && !core_rst_q) begin
      cause_q <= 3'h5;
    end else if (mode_q == lpm_pkg::MODE_STOP && stop_wake && wake_cnt_q == 16'h0000) begin
      cause_q <= 3'h4;
    end else if (reg_wr && reg_addr == `LPM_ADDR_CAUSE) begin
      cause_q <= 3'h0;
    end
  end

  // Clock, oscillator and regulator plan for each mode
  always_comb begin
    osc_d = '{pll_en: 1'b1, msi_en: 1'b1, msi_min: 1'b0, hsi_en: 1'b1,
              hse_en: 1'b1, lse_en: 1'b1, lsi_en: 1'b1};
    dom_d = '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, core_pwr_on: 1'b1,
              reg_low_power: 1'b0, ram_retained: 1'b1};
    if (range_q == 2'h3) begin
      // Only the multispeed oscillator may feed the system in range 3
      osc_d.pll_en = 1'b0;
      osc_d.hsi_en = 1'b0;
      osc_d.hse_en = 1'b0;
    end
    case (mode_d)
      lpm_pkg::MODE_SLEEP: begin
        dom_d.cpu_clk_en = 1'b0;
      end
      lpm_pkg::MODE_LP_RUN, lpm_pkg::MODE_LP_SLEEP: begin
        osc_d.pll_en        = 1'b0;
        osc_d.hsi_en        = 1'b0;
        osc_d.hse_en        = 1'b0;
        osc_d.msi_min       = 1'b1;
        dom_d.reg_low_power = 1'b1;
        dom_d.cpu_clk_en    = (mode_d == lpm_pkg::MODE_LP_RUN);
      end
      lpm_pkg::MODE_STOP: begin
        osc_d = '{pll_en: 1'b0, msi_en: 1'b0, msi_min: 1'b0, hsi_en: 1'b0,
                  hse_en: 1'b0, lse_en: keep_rtc_q, lsi_en: keep_rtc_q};
        dom_d.cpu_clk_en    = 1'b0;
        dom_d.periph_clk_en = 1'b0;
        dom_d.reg_low_power = 1'b1;
      end
      lpm_pkg::MODE_STANDBY: begin
        osc_d = '{pll_en: 1'b0, msi_en: 1'b0, msi_min: 1'b0, hsi_en: 1'b0,
                  hse_en: 1'b0, lse_en: keep_rtc_q, lsi_en: keep_rtc_q};
        dom_d = '{cpu_clk_en: 1'b0, periph_clk_en: 1'b0, core_pwr_on: 1'b0,
                  reg_low_power: 1'b0, ram_retained: 1'b0};
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_q          <= '{default: 1'b1, msi_min: 1'b0};
      dom_q          <= '{default: 1'b1, reg_low_power: 1'b0};
      rtc_wdg_keep_q <= 1'b1;
    end else begin
      osc_q          <= osc_d;
      dom_q          <= dom_d;
      rtc_wdg_keep_q <= 1'b1;
    end
  end

  // Register readback
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `LPM_ADDR_CTRL:    rdata_d = {8'h00, vref_q, go_q, keep_rtc_q, range_q, req_mode_q};
      `LPM_ADDR_WAKE_EN: rdata_d = line_en_q;
      `LPM_ADDR_STATUS:  rdata_d = {12'h000, core_rst_q, mode_q};
      `LPM_ADDR_CAUSE:   rdata_d = {13'h0000, cause_q};
      default:           rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // low_power_mode_controller

// ===== shared/lpm_regs.svh
// Timing counts, register offsets and field positions of the power-mode controller
// Overview of operation
// - Sleep halts only processor clock
// - Any interrupt or event wakes Sleep
// - Low power run: multispeed minimum, regulator low
// - Low power sleep: Sleep with regulator low
// - Low power sleep wake restores run, regulator on
// - Stop with RTC keeps both slow oscillators
// - Stop without RTC stops every clock
// - Enabled external lines wake Stop within 8 us
// - Stop with RTC adds the RTC sources
// - Stop without RTC: lines, detector, comparators, USB
// - Standby turns regulator and fast oscillators off
// - Standby loses RAM; standby circuitry survives
// - Standby with RTC exits within 60 us
// - Standby without RTC: reset pin or wake pin
// - Stop/Standby never halt RTC, watchdog; their clocks run only with RTC kept
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

`define LPM_CLK_KHZ        25000
`define LPM_STOP_WAKE_NS   8000
`define LPM_STBY_WAKE_NS   60000
`define LPM_STOP_WAKE_CYC  ((`LPM_STOP_WAKE_NS * `LPM_CLK_KHZ) / 1000000)
`define LPM_STBY_WAKE_CYC  ((`LPM_STBY_WAKE_NS * `LPM_CLK_KHZ) / 1000000)
`define LPM_STOP_WAKE_NEED 4
`define LPM_STBY_RST_CYC   8

`define LPM_ADDR_CTRL      4'h0
`define LPM_ADDR_WAKE_EN   4'h1
`define LPM_ADDR_STATUS    4'h2
`define LPM_ADDR_CAUSE     4'h3

`define LPM_CTRL_MODE_LSB  0
`define LPM_CTRL_MODE_MSB  2
`define LPM_CTRL_RANGE_LSB 3
`define LPM_CTRL_RANGE_MSB 4
`define LPM_CTRL_RTC_BIT   5
`define LPM_CTRL_GO_BIT    6
`define LPM_CTRL_VREF_BIT  7

`define LPM_WAKE_EN_RESET  16'hFFFF
`define LPM_RANGE_RESET    2'h2

`endif

// ===== shared/lpm_pkg.sv
// Types shared by the power-mode controller
package lpm_pkg;
  typedef enum logic [2:0] {
    MODE_RUN      = 3'b000,
    MODE_SLEEP    = 3'b001,
    MODE_LP_RUN   = 3'b010,
    MODE_LP_SLEEP = 3'b011,
    MODE_STOP     = 3'b100,
    MODE_STANDBY  = 3'b101
  } mode_e;

  typedef struct packed {
    logic pll_en;
    logic msi_en;
    logic msi_min;
    logic hsi_en;
    logic hse_en;
    logic lse_en;
    logic lsi_en;
  } osc_s;

  typedef struct packed {
    logic       cpu_clk_en;
    logic       periph_clk_en;
    logic       core_pwr_on;
    logic       reg_low_power;
    logic       ram_retained;
  } dom_s;

  typedef struct packed {
    logic [15:0] ext_line;
    logic        volt_det;
    logic        comp1;
    logic        comp2;
    logic        rtc_alarm;
    logic        usb_wake;
    logic        rtc_tamper;
    logic        rtc_stamp;
    logic        rtc_wakeup;
  } stop_src_s;

  typedef struct packed {
    logic [2:0] wake_pin;
    logic       ext_reset_pin;
    logic       wdg_reset;
    logic       alarm_a;
    logic       alarm_b;
    logic       rtc_tamper;
    logic       rtc_stamp;
    logic       rtc_wakeup;
  } stby_src_s;
endpackage

// ===== rtl/stop_wake_gate.sv
// Wake source qualification for Stop mode
module stop_wake_gate (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire lpm_pkg::stop_src_s src,
  input  wire logic [15:0]       line_en,
  input  wire logic              keep_rtc,
  input  wire logic              vref_on,
  output logic                   wake_q
);
  logic [15:0] line_hit;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_line
      assign line_hit[g] = src.ext_line[g] & line_en[g];
    end
  endgenerate

  logic wake_d;
  always_comb begin
    wake_d = (|line_hit) | src.volt_det | src.usb_wake
           | (vref_on & (src.comp1 | src.comp2));
    if (keep_rtc) begin
      wake_d = wake_d | src.rtc_alarm | src.rtc_tamper | src.rtc_stamp
             | src.rtc_wakeup;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end
endmodule // stop_wake_gate

// ===== rtl/stby_wake_gate.sv
// Wake source qualification for Standby mode, with wake pin edge detect
module stby_wake_gate (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire lpm_pkg::stby_src_s src,
  input  wire logic               keep_rtc,
  output logic                    wake_q
);
  logic [2:0] pin_prev_q;
  logic       wake_d;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev_q <= 3'h0;
    end else begin
      pin_prev_q <= src.wake_pin;
    end
  end

  always_comb begin
    wake_d = src.ext_reset_pin | (|(src.wake_pin & ~pin_prev_q));
    if (keep_rtc) begin
      wake_d = wake_d | src.wdg_reset | src.alarm_a | src.alarm_b
             | src.rtc_tamper | src.rtc_stamp | src.rtc_wakeup;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end
endmodule // stby_wake_gate

// ===== sim/lpm_properties.sv
// Checker of mode outputs against wake inputs of the power-mode controller
module lpm_properties (
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  input wire logic               irq_or_event,
  input wire lpm_pkg::stop_src_s stop_src,
  input wire lpm_pkg::stby_src_s stby_src,
  input wire lpm_pkg::mode_e     mode_q,
  input wire lpm_pkg::osc_s      osc_q,
  input wire lpm_pkg::dom_s      dom_q,
  input wire logic               core_rst_q,
  input wire logic               rtc_wdg_keep_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire fast_on = osc_q.pll_en | osc_q.msi_en | osc_q.hsi_en | osc_q.hse_en;

  a_sleep_cpu_only: assert property (mode_q == lpm_pkg::MODE_SLEEP
    |-> !dom_q.cpu_clk_en && dom_q.periph_clk_en) else $error("sleep clocks wrong");
  a_sleep_irq_wake: assert property (mode_q == lpm_pkg::MODE_SLEEP && irq_or_event
    |=> mode_q == lpm_pkg::MODE_RUN) else $error("sleep did not wake");
  a_lprun_msi_min: assert property (mode_q == lpm_pkg::MODE_LP_RUN
    |-> osc_q.msi_en && osc_q.msi_min && dom_q.reg_low_power) else $error("lp run setup");
  a_lpsleep_wake_run: assert property (mode_q == lpm_pkg::MODE_LP_SLEEP && irq_or_event
    |=> mode_q == lpm_pkg::MODE_RUN && !dom_q.reg_low_power) else $error("lp sleep exit");
  a_stop_osc_off: assert property (mode_q == lpm_pkg::MODE_STOP
    |-> !fast_on && dom_q.reg_low_power && dom_q.ram_retained) else $error("stop setup");
  a_stop_line_wake: assert property (mode_q == lpm_pkg::MODE_STOP && stop_src.ext_line[0]
    |-> ##[1:200] mode_q != lpm_pkg::MODE_STOP) else $error("stop wake late");
  a_stby_power_off: assert property (mode_q == lpm_pkg::MODE_STANDBY
    |-> !dom_q.core_pwr_on && !fast_on && !dom_q.ram_retained) else $error("standby setup");
  a_stby_pin_wake: assert property (mode_q == lpm_pkg::MODE_STANDBY
    && $rose(|stby_src.wake_pin) |-> ##[1:1000] mode_q == lpm_pkg::MODE_RUN)
    else $error("standby wake late");
  a_stby_exit_reset: assert property ($fell(mode_q == lpm_pkg::MODE_STANDBY)
    |-> $past(core_rst_q) && mode_q == lpm_pkg::MODE_RUN) else $error("no core reset");
  a_rtc_kept: assert property (rtc_wdg_keep_q) else $error("rtc or watchdog stopped");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule // lpm_properties

bind low_power_mode_controller lpm_properties i_props (.sys_clk, .sys_rst, .reg_rd,
  .reg_rdata, .irq_or_event, .stop_src, .stby_src, .mode_q, .osc_q, .dom_q, .core_rst_q,
  .rtc_wdg_keep_q);

// ===== sim/lpm_core_model.sv
// Model of the processor core and the wake sources beside the power-mode controller
module lpm_core_model (
  input  wire logic               sys_clk,
  input  wire lpm_pkg::mode_e     mode_q,
  output lpm_pkg::stop_src_s      stop_src,
  output lpm_pkg::stby_src_s      stby_src,
  output logic                    cpu_wait,
  output logic                    irq_or_event
);
  timeunit 1ns;
  timeprecision 1ns;
  // Core stays on the reset clock setting, inside every range and step limit
  initial begin
    cpu_wait = 1'b0;
    irq_or_event = 1'b0;
    stop_src = '0;
    stby_src = '0;
  end
  // A halted core no longer executes, so its wait request drops
  always @(posedge sys_clk) begin
    if (mode_q != lpm_pkg::MODE_RUN) cpu_wait <= 1'b0;
  end
  task automatic wfi();
    @(posedge sys_clk) cpu_wait <= 1'b1;
  endtask
  task automatic irq();
    @(posedge sys_clk) irq_or_event <= 1'b1;
    @(posedge sys_clk) irq_or_event <= 1'b0;
  endtask
  task automatic pulse_stop(input lpm_pkg::stop_src_s v);
    @(posedge sys_clk) stop_src <= v;
    @(posedge sys_clk) stop_src <= '0;
  endtask
  task automatic pulse_stby(input lpm_pkg::stby_src_s v);
    @(posedge sys_clk) stby_src <= v;
    @(posedge sys_clk) stby_src <= '0;
  endtask
endmodule // lpm_core_model

// ===== sim/low_power_mode_controller_test.sv
// Testbench of the power-mode controller: register access and mode walks
module low_power_mode_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk;
  logic               sys_rst;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        reg_rdata;
  logic               cpu_wait;
  logic               irq_or_event;
  lpm_pkg::stop_src_s stop_src;
  lpm_pkg::stby_src_s stby_src;
  lpm_pkg::mode_e     mode_q;
  lpm_pkg::osc_s      osc_q;
  lpm_pkg::dom_s      dom_q;
  logic               core_rst_q;
  logic               rtc_wdg_keep_q;
  int                 bad_count = 0;
  int                 n_compared = 0;
  int                 cyc = 0;

  low_power_mode_controller i_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cpu_wait, .irq_or_event, .stop_src, .stby_src, .mode_q, .osc_q,
    .dom_q, .core_rst_q, .rtc_wdg_keep_q);
  lpm_core_model i_core (.sys_clk, .mode_q, .stop_src, .stby_src, .cpu_wait, .irq_or_event);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wait_mode(input lpm_pkg::mode_e m, input int lim);
    int i;
    i = 0;
    while (mode_q !== m && i < lim) begin
      @(posedge sys_clk);
      #1 i++;
    end
    chk(mode_q, m);
  endtask
  task automatic enter(input logic [15:0] c, input lpm_pkg::mode_e m);
    wr(4'h0, c);
    i_core.wfi();
    wait_mode(m, 10);
  endtask
  // Refused source first, then the source that must end the mode in time
  task automatic stop_case(input logic [15:0] c, input logic [23:0] nb, input logic [23:0] g);
    enter(c, lpm_pkg::MODE_STOP);
    chk({osc_q.pll_en, osc_q.msi_en, osc_q.hsi_en, osc_q.hse_en, dom_q.cpu_clk_en}, 5'h00);
    chk(osc_q.lse_en | osc_q.lsi_en, c[5]);
    i_core.pulse_stop(nb);
    repeat (20) @(posedge sys_clk);
    chk(mode_q, lpm_pkg::MODE_STOP);
    i_core.pulse_stop(g);
    wait_mode(lpm_pkg::MODE_RUN, 200);
  endtask
  task automatic stby_case(input logic [15:0] c, input logic [9:0] nb, input logic [9:0] g);
    int i;
    enter(c, lpm_pkg::MODE_STANDBY);
    chk({dom_q.core_pwr_on, dom_q.ram_retained, osc_q.pll_en, osc_q.hsi_en}, 4'h0);
    chk(rtc_wdg_keep_q, 1'b1);
    i_core.pulse_stby(nb);
    repeat (20) @(posedge sys_clk);
    chk(mode_q, lpm_pkg::MODE_STANDBY);
    i_core.pulse_stby(g);
    for (i = 0; i < 20 && core_rst_q !== 1'b1; i++) @(posedge sys_clk);
    chk(core_rst_q, 1'b1);
    wait_mode(lpm_pkg::MODE_RUN, 1500);
  endtask

  initial begin
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 16'h0030);
    rd(4'h1, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(4'h0, 16'h0018);
    @(posedge sys_clk);
    #1 chk({osc_q.pll_en, osc_q.hsi_en, osc_q.hse_en, osc_q.msi_en}, 4'h1);
    wr(4'h0, 16'h0030);
    enter(16'h0071, lpm_pkg::MODE_SLEEP);
    chk({dom_q.cpu_clk_en, dom_q.periph_clk_en}, 2'b01);
    i_core.irq();
    wait_mode(lpm_pkg::MODE_RUN, 3);
    wr(4'h0, 16'h0072);
    wait_mode(lpm_pkg::MODE_LP_RUN, 10);
    chk({osc_q.msi_en, osc_q.msi_min, dom_q.reg_low_power}, 3'b111);
    wr(4'h0, 16'h0070);
    wait_mode(lpm_pkg::MODE_RUN, 10);
    enter(16'h0073, lpm_pkg::MODE_LP_SLEEP);
    chk({dom_q.cpu_clk_en, dom_q.reg_low_power}, 2'b01);
    i_core.irq();
    wait_mode(lpm_pkg::MODE_RUN, 3);
    chk(dom_q.reg_low_power, 1'b0);
    wr(4'h1, 16'hFFFD);
    stop_case(16'h0074, 24'h000200, 24'h000100);
    stop_case(16'h0074, 24'h000040, 24'h000010);
    stop_case(16'h0054, 24'h000010, 24'h000008);
    stop_case(16'h00F4, 24'h000200, 24'h000040);
    rd(4'h3, 16'h0004);
    wr(4'h0, 16'h0076);
    i_core.wfi();
    repeat (5) @(posedge sys_clk);
    chk(mode_q, lpm_pkg::MODE_RUN);
    stby_case(16'h0055, 10'h020, 10'h200);
    stby_case(16'h0075, 10'h000, 10'h020);
    stby_case(16'h0075, 10'h000, 10'h008);
    rd(4'h3, 16'h0005);
    rd(4'h2, 16'h0000);
    wr(4'h3, 16'h0000);
    rd(4'h3, 16'h0000);
    test_done();
  end
endmodule // low_power_mode_controller_test
